// ==== include/adc_seq_pkg.sv ====
// Constants and types for the simultaneous-sampling converter sequencer
package adc_seq_pkg;
	localparam int        CLK_HZ          = 50_000_000;
	localparam int        CONV_SLOT_NS    = 3000;
	localparam int        CONV_SLOT_CYC   = (CONV_SLOT_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int        SLOT_CNT_W      = 8;
	localparam int        RESULT_W        = 14;
	localparam int        CHANNELS        = 4;
	localparam int        MODE_W          = 4;
	localparam int        MODE_PD_BIT     = 3;
	localparam int        MODE_BANK_BIT   = 2;
	localparam logic [3:0] MODE_RESET     = 4'h0;
	localparam logic [1:0] CH_FIRST       = 2'h0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CONVERT,
		ST_STORE
	} seq_state_t;
endpackage

// ==== sim/host_bus_model.sv ====
// Host processor model on the parallel bus
`timescale 1ns/1ps
module host_bus_model
	import adc_seq_pkg::*;
(
	// Clock and read-back
	input  wire logic                core_clk,
	input  wire logic [RESULT_W-1:0] data_out,
	input  wire logic                data_oe_n,
	// Bus strobes and pin drive
	output logic                     chip_select_n,
	output logic                     write_n,
	output logic                     read_n,
	output logic      [RESULT_W-1:0] host_data
);
	initial begin
		chip_select_n = 1'b1;
		write_n = 1'b1;
		read_n = 1'b1;
		host_data = 14'h2AAA;
	end
	// Code held until both strobes are back high
	task automatic wr_mode(input logic [3:0] code, input logic csn);
		@(posedge core_clk);
		chip_select_n <= csn;
		write_n <= 1'b0;
		host_data <= {10'h000, code};
		repeat (2) @(posedge core_clk);
		write_n <= 1'b1;
		chip_select_n <= 1'b1;
		@(posedge core_clk);
		host_data <= ~host_data;
		@(posedge core_clk);
	endtask
	// Select is left low so reads run back to back
	task automatic rd_word(input logic csn, output logic [RESULT_W-1:0] d, output logic oe);
		@(posedge core_clk);
		chip_select_n <= csn;
		read_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		d = data_out;
		oe = data_oe_n;
		read_n <= 1'b1;
		@(posedge core_clk);
	endtask
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
	import adc_seq_pkg::*;
	logic                core_clk = 1'b0;
	logic                sys_rst, chip_select_n, write_n, read_n, conversion_start;
	logic                data_oe_n, track_hold_n, bank_b_select, power_down, done_n, oe;
	logic [1:0]          convert_channel;
	logic [RESULT_W-1:0] host_data, data_out, conv_result, d;
	wire  [RESULT_W-1:0] data_in = data_oe_n ? host_data : data_out;
	int                  failures, tests_run, k, j, n, w;
	// Row: mode code, bank, channel count
	localparam logic [7:0] ROWS [0:7] = '{8'h01, 8'h12, 8'h23, 8'h34, 8'h49, 8'h5A, 8'h6B, 8'h7C};

	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) conv_result <= {1'b1, bank_b_select, 10'h155, convert_channel};

	adc_sequencer u_adc_sequencer (.core_clk(core_clk), .sys_rst(sys_rst),
		.chip_select_n(chip_select_n), .write_n(write_n), .read_n(read_n),
		.conversion_start(conversion_start), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .conv_result(conv_result), .track_hold_n(track_hold_n),
		.bank_b_select(bank_b_select), .convert_channel(convert_channel),
		.power_down(power_down), .done_n(done_n));
	host_bus_model u_host_bus_model (.core_clk(core_clk), .data_out(data_out),
		.data_oe_n(data_oe_n), .chip_select_n(chip_select_n), .write_n(write_n),
		.read_n(read_n), .host_data(host_data));

	task automatic check(input string nm, input logic [RESULT_W-1:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic start_seq;
		@(posedge core_clk) conversion_start <= 1'b1;
		@(posedge core_clk) conversion_start <= 1'b0;
	endtask
	task automatic wait_done(input int lim);
		w = 0;
		while (done_n !== 1'b0 && w < lim) begin
			@(posedge core_clk);
			w++;
		end
		if (w >= lim) begin
			check("done_wait", 0, 1);
			tally_and_finish();
		end else begin
			#1;
		end
	endtask

	initial begin
		failures = 0;
		tests_run = 0;
		sys_rst = 1'b1;
		conversion_start = 1'b0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check("done_rst", done_n, 1);
		check("oe_rst", data_oe_n, 1);
		check("mode_rst", {power_down, bank_b_select}, 0);
		for (k = 0; k < 8; k++) begin
			n = ROWS[k][2:0];
			u_host_bus_model.wr_mode(ROWS[k][7:4], 1'b0);
			start_seq();
			repeat (5) @(posedge core_clk);
			check("hold", track_hold_n, 0);
			wait_done(CONV_SLOT_CYC * 4 + 20);
			check("slots", w > (n - 1) * CONV_SLOT_CYC && w < n * CONV_SLOT_CYC + 10, 1);
			check("track", track_hold_n, 1);
			check("bank", bank_b_select, ROWS[k][3]);
			for (j = 0; j <= n; j++) begin
				u_host_bus_model.rd_word(1'b0, d, oe);
				check("data", d, {1'b1, ROWS[k][3], 10'h155, 2'(j % n)});
				check("oe_read", oe, 0);
				check("done_read", done_n, 1);
			end
		end
		start_seq();
		repeat (300) @(posedge core_clk);
		start_seq();
		wait_done(CONV_SLOT_CYC * 4);
		u_host_bus_model.rd_word(1'b0, d, oe);
		repeat (700) @(posedge core_clk);
		check("busy_start", done_n, 1);
		u_host_bus_model.wr_mode(4'h8, 1'b0);
		check("pd", power_down, 1);
		start_seq();
		repeat (700) @(posedge core_clk);
		check("pd_done", {done_n, track_hold_n}, 2'h3);
		u_host_bus_model.wr_mode(4'h4, 1'b1);
		check("cs_wr", {power_down, bank_b_select}, 2'h2);
		u_host_bus_model.rd_word(1'b1, d, oe);
		check("cs_rd", oe, 1);
		tally_and_finish();
	end
endmodule

// ==== src/adc_sequencer.sv ====
// Sequencer, result memory and parallel host interface of the converter
//
// What this block does
// - A rising edge on conversion_start samples all four inputs of the chosen bank and starts the sequence.
// - Each channel takes one 3 us slot and its 14-bit result goes to its own word of a four-word memory.
// - Start pulses are ignored while a sequence is still running.
// - After the last conversion done_n goes low and the track/holds return to tracking.
// - One to four channels of bank A or bank B are converted, all sampled together.
// - Reads are sequential only; the first read after a sequence returns channel one.
// - After all programmed channels are read the pointer wraps back to channel one.
// - Chip select may stay low across a series of read strobes.
// - Timing derives from the clock, the start input, the programmed mode and the read strobes, which hold off buffer stores and done_n.
// - Results use a 14-bit bus, bit 13 most significant; the low four bits also carry the mode code.
// - Mode bit 3 is power-down, bit 2 selects bank B, bits 1:0 are channel count minus one; zero at reset.
// - The mode code is latched on the rising edge of write or chip select and kept until rewritten.
// - done_n returns high on the first read falling edge; the pointer advances on each read rising edge.
// - With chip select high, write and read are ignored and the data pins are released.
`timescale 1ns/1ps
module adc_sequencer
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// Control strobes from host
	input  wire logic                  chip_select_n,
	input  wire logic                  write_n,
	input  wire logic                  read_n,
	input  wire logic                  conversion_start,
	// Bidirectional data pins
	input  wire logic [RESULT_W-1:0]   data_in,
	output logic      [RESULT_W-1:0]   data_out,
	output logic                       data_oe_n,
	// Converter core
	input  wire logic [RESULT_W-1:0]   conv_result,
	output logic                       track_hold_n,
	output logic                       bank_b_select,
	output logic      [1:0]            convert_channel,
	output logic                       power_down,
	// Completion
	output logic                       done_n
);
	// Converted words flow through a two-entry buffer into the memory
	logic [RESULT_W-1:0] mem_reg [CHANNELS];
	logic [MODE_W-1:0]   mode_reg;
	logic [MODE_W-1:0]   wr_code_reg;
	logic [1:0]          rd_ptr_reg;
	logic [1:0]          conv_ch_reg;
	logic [SLOT_CNT_W-1:0] slot_cnt_reg;
	seq_state_t          state_reg;
	logic                start_d_reg;
	logic                wr_cycle_reg;
	logic                rd_d_reg;
	logic                first_rd_reg;
	logic [RESULT_W-1:0] data_out_reg;
	logic                data_oe_n_reg;
	logic                track_hold_n_reg;
	logic                done_n_reg;
	logic [RESULT_W-1:0] buf_data_reg [2];
	logic [1:0]          buf_ch_reg [2];
	logic                buf_wp_reg;
	logic                buf_rp_reg;
	logic [1:0]          buf_cnt_reg;

	function automatic logic [1:0] ptr_step(input logic [1:0] p, input logic [1:0] last);
		ptr_step = (p == last) ? CH_FIRST : p + 2'h1;
	endfunction

	wire       cs_active   = !chip_select_n;
	wire       wr_active   = cs_active && !write_n;
	wire       wr_release  = wr_cycle_reg && !wr_active;
	wire       rd_active   = cs_active && !read_n;
	wire       rd_fall     = rd_active && !rd_d_reg;
	wire       rd_rise     = !rd_active && rd_d_reg;
	wire       pd_mode     = mode_reg[MODE_PD_BIT];
	wire [1:0] last_ch     = mode_reg[1:0];
	wire       start_rise  = conversion_start && !start_d_reg;
	wire       start_take  = start_rise && (state_reg == ST_IDLE) && !pd_mode;
	wire       slot_end    = slot_cnt_reg == SLOT_CNT_W'(CONV_SLOT_CYC - 1);
	wire       buf_in_rdy  = buf_cnt_reg != 2'h2;
	wire       buf_in_vld  = (state_reg == ST_CONVERT) && slot_end;
	wire       buf_out_vld = buf_cnt_reg != 2'h0;
	wire       buf_out_rdy = !rd_active;
	wire       buf_push    = buf_in_vld && buf_in_rdy;
	wire       buf_pop     = buf_out_vld && buf_out_rdy;
	wire       last_slot   = conv_ch_reg == last_ch;
	wire       seq_done    = (state_reg == ST_STORE) && !buf_out_vld;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_d_reg  <= 1'b0;
			wr_cycle_reg <= 1'b0;
			rd_d_reg     <= 1'b0;
			wr_code_reg  <= MODE_RESET;
			mode_reg     <= MODE_RESET;
		end else begin
			start_d_reg  <= conversion_start;
			wr_cycle_reg <= wr_active;
			rd_d_reg     <= rd_active;
			// Code is staged while the strobe is low, applied at its release
			if (wr_active)
				wr_code_reg <= data_in[MODE_W-1:0];
			if (wr_release)
				mode_reg <= wr_code_reg;
		end
	end

	// Sequencer: sample, then one slot per channel, then drain buffer
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg        <= ST_IDLE;
			conv_ch_reg      <= CH_FIRST;
			slot_cnt_reg     <= '0;
			track_hold_n_reg <= 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_take) begin
						state_reg        <= ST_CONVERT;
						track_hold_n_reg <= 1'b0;
						conv_ch_reg      <= CH_FIRST;
						slot_cnt_reg     <= '0;
					end
				end
				ST_CONVERT: begin
					if (!slot_end)
						slot_cnt_reg <= slot_cnt_reg + 1'b1;
					else if (buf_push) begin
						slot_cnt_reg <= '0;
						if (last_slot)
							state_reg <= ST_STORE;
						else
							conv_ch_reg <= conv_ch_reg + 2'h1;
					end
				end
				ST_STORE: begin
					if (seq_done) begin
						state_reg        <= ST_IDLE;
						track_hold_n_reg <= 1'b1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Two-entry buffer between converter and result memory
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			buf_wp_reg  <= 1'b0;
			buf_rp_reg  <= 1'b0;
			buf_cnt_reg <= 2'h0;
		end else begin
			if (buf_push) begin
				buf_data_reg[buf_wp_reg] <= conv_result;
				buf_ch_reg[buf_wp_reg]   <= conv_ch_reg;
				buf_wp_reg               <= !buf_wp_reg;
			end
			if (buf_pop) begin
				mem_reg[buf_ch_reg[buf_rp_reg]] <= buf_data_reg[buf_rp_reg];
				buf_rp_reg                       <= !buf_rp_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// Read side, done flag and pin drive
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_ptr_reg    <= CH_FIRST;
			done_n_reg    <= 1'b1;
			first_rd_reg  <= 1'b0;
			data_out_reg  <= '0;
			data_oe_n_reg <= 1'b1;
		end else begin
			data_oe_n_reg <= !rd_active;
			if (rd_active)
				data_out_reg <= mem_reg[rd_ptr_reg];
			if (seq_done) begin
				done_n_reg   <= 1'b0;
				rd_ptr_reg   <= CH_FIRST;
				first_rd_reg <= 1'b1;
			end else begin
				if (rd_fall && first_rd_reg) begin
					done_n_reg   <= 1'b1;
					first_rd_reg <= 1'b0;
				end
				if (rd_rise)
					rd_ptr_reg <= ptr_step(rd_ptr_reg, last_ch);
			end
		end
	end

	assign data_out        = data_out_reg;
	assign data_oe_n       = data_oe_n_reg;
	assign track_hold_n    = track_hold_n_reg;
	assign done_n          = done_n_reg;
	assign bank_b_select   = mode_reg[MODE_BANK_BIT];
	assign convert_channel = conv_ch_reg;
	assign power_down      = mode_reg[MODE_PD_BIT];

	// Checks
	start_busy_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(state_reg == ST_CONVERT && !slot_end && start_rise) |=> slot_cnt_reg != '0 && !track_hold_n)
		else $error("start taken while busy");
	mode_latch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		wr_release |=> mode_reg == $past(wr_code_reg))
		else $error("mode not latched at strobe release");
	mode_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!wr_release |=> $stable(mode_reg))
		else $error("mode changed without a write");
	start_take_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		start_take |=> !track_hold_n && state_reg == ST_CONVERT)
		else $error("start edge did not begin sequence");
	slot_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(state_reg == ST_CONVERT) |-> (state_reg == ST_CONVERT) [*8])
		else $error("conversion slot too short");
	done_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		seq_done |=> !done_n && track_hold_n)
		else $error("done not signalled");
	pd_ignore_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(pd_mode && state_reg == ST_IDLE) |=> state_reg == ST_IDLE)
		else $error("start accepted in power-down");
	rd_release_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		chip_select_n |=> data_oe_n)
		else $error("pins driven without select");
	done_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_fall && first_rd_reg && !seq_done) |=> done_n)
		else $error("done not cleared by read");
	ptr_wrap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(rd_rise && !seq_done && rd_ptr_reg == last_ch) |=> rd_ptr_reg == CH_FIRST)
		else $error("read pointer failed to wrap");
	ptr_first_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		seq_done |=> rd_ptr_reg == CH_FIRST)
		else $error("read pointer not at first channel");
endmodule
